// ---- logic/smbus_port_params.svh ----
// Constants for the SMBus block target port.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef SMBUS_PORT_PARAMS_SVH
`define SMBUS_PORT_PARAMS_SVH

// ****************************************************************
// Address assignment
// ****************************************************************
`define ADDR_FIXED 4'hd
`define STRAP_LOW 2'h0
`define STRAP_MID 2'h1
`define STRAP_HIGH 2'h2
`define ADDR_LOW_FOR_LOW 3'h0
`define ADDR_LOW_FOR_MID 3'h1
`define ADDR_LOW_FOR_HIGH 3'h2

// ****************************************************************
// Byte framing and store
// ****************************************************************
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_FIRST 4'h0
`define CFG_BYTES 8'h08
`define CFG_IMAGE_W 64
`define LINE_IDLE 2'h3

`endif

// ---- logic/smbus_port_pkg.sv ----
// Types shared by the SMBus block target port.
// Assumes nothing of its surroundings.
package smbus_port_pkg;

    // ****************************************************************
    // Link states
    // ****************************************************************
    typedef enum logic [6:0] {
        st_addr = 7'h01,
        st_loc = 7'h02,
        st_count = 7'h04,
        st_wdata = 7'h08,
        st_rcount = 7'h10,
        st_rdata = 7'h20,
        st_ignore = 7'h40
    } link_state_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [3:0] fixed;
        logic [2:0] low;
    } bus_addr_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_lines_t;

endpackage

// ---- logic/two_flop_sync.sv ----
// Two flip-flop synchroniser for levels entering a clock domain.
// Assumes the input is a level that holds for several clock edges.
`timescale 1ns/1ps
`default_nettype none

module two_flop_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // ****************************************************************
    // Capture stages
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        meta <= d;
        q <= meta;
    end

endmodule

`default_nettype wire

// ---- logic/smbus_block_target_port.sv ----
// SMBus block read and block write target port with a small byte store.
// Assumes scl and sda_in come from the bus, the wire level is resolved
// outside from sda_oe, and clk runs much faster than scl.
//
// How it works
// - The port only answers as a target at one 7-bit address with a
//      direction bit, for block write and block read.
// - The host may stop after any whole byte and bytes already moved stay.
// - Address bits A6 to A3 are fixed at 1101, the low bits come from the
//      address selection.
// - The low address bits are latched once from the strap pin.
// - Block write is location, count, then data from that location on,
//      and the port acknowledges every byte.
// - Block read returns the store size 8 as count then data from the location; the host
//      acks each byte and ends with a not-acknowledge and stop.
`include "smbus_port_params.svh"
`timescale 1ns/1ps
`default_nettype none

module smbus_block_target_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] three_level_address_strap_pin,
    output logic [2:0] bus_address_strap,
    output logic [`CFG_IMAGE_W-1:0] cfg_image
);

    // ****************************************************************
    // System side: line sampling and start, stop detection
    // ****************************************************************
    smbus_port_pkg::bus_lines_t lines_raw;
    smbus_port_pkg::bus_lines_t lines_s;
    smbus_port_pkg::bus_lines_t lines_d;
    logic frame_clear;
    logic link_init;
    logic copy_now;
    wire start_seen;
    wire stop_seen;

    assign lines_raw = {scl, sda_in};

    two_flop_sync #(.W(2)) u_line_sync (
        .clk(clk),
        .d(lines_raw),
        .q(lines_s)
    );

    assign start_seen = lines_s.scl && lines_d.scl && lines_d.sda
        && !lines_s.sda;
    assign stop_seen = lines_s.scl && lines_d.scl && !lines_d.sda
        && lines_s.sda;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lines_d <= `LINE_IDLE;
            frame_clear <= 1'b1;
            copy_now <= 1'b0;
        end
        else
        begin
            lines_d <= lines_s;
            frame_clear <= start_seen || stop_seen;
            copy_now <= stop_seen;
        end
    end

    always_ff @(posedge clk)
    begin
        link_init <= rst;
        sda_out <= 1'b0;
    end

    // ****************************************************************
    // Address strap latch
    // ****************************************************************
    logic [1:0] strap_s;
    logic strap_taken;
    wire [2:0] strap_low;

    two_flop_sync #(.W(2)) u_strap_sync (
        .clk(clk),
        .d(three_level_address_strap_pin),
        .q(strap_s)
    );

    assign strap_low = (strap_s == `STRAP_LOW) ? `ADDR_LOW_FOR_LOW :
        (strap_s == `STRAP_HIGH) ? `ADDR_LOW_FOR_HIGH : `ADDR_LOW_FOR_MID;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            strap_taken <= 1'b0;
            bus_address_strap <= 3'h0;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            bus_address_strap <= strap_low;
        end
    end

    // ****************************************************************
    // Link side: bit framing on the bus clock
    // ****************************************************************
    smbus_port_pkg::link_state_t state;
    smbus_port_pkg::link_state_t next_state;
    smbus_port_pkg::bus_addr_t own_addr;
    logic [2:0] addr_low_link;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] loc;
    logic [7:0] count;
    logic [7:0] tx;
    logic [7:0] mem [0:`CFG_BYTES-1];
    logic ack;
    logic next_ack;
    wire [7:0] rx_byte;
    wire [7:0] rd_byte;
    wire transmitting;
    wire addr_match;
    wire byte_end;
    wire ack_slot;
    wire in_range;
    wire next_sda_oe;

    two_flop_sync #(.W(3)) u_addr_sync (
        .clk(scl),
        .d(bus_address_strap),
        .q(addr_low_link)
    );

    assign own_addr = {`ADDR_FIXED, addr_low_link};
    assign rx_byte = {shift[6:0], sda_in};
    assign byte_end = (bit_cnt == `BIT_LAST);
    assign ack_slot = (bit_cnt == `BIT_ACK);
    assign addr_match = (rx_byte[7:1] == own_addr);
    assign transmitting = (state == smbus_port_pkg::st_rcount)
        || (state == smbus_port_pkg::st_rdata);
    assign in_range = (loc < `CFG_BYTES);
    assign rd_byte = in_range ? mem[loc[2:0]] : 8'h00;

    always_comb
    begin
        next_state = state;
        next_ack = ack;
        if (ack_slot)
        begin
            next_ack = 1'b0;
            if (transmitting && !ack)
            begin
                next_state = sda_in ? smbus_port_pkg::st_ignore
                    : smbus_port_pkg::st_rdata;
            end
        end
        else if (byte_end)
        begin
            case (state)
                smbus_port_pkg::st_addr:
                begin
                    next_ack = addr_match;
                    if (!addr_match)
                        next_state = smbus_port_pkg::st_ignore;
                    else if (rx_byte[0])
                        next_state = smbus_port_pkg::st_rcount;
                    else
                        next_state = smbus_port_pkg::st_loc;
                end
                smbus_port_pkg::st_loc:
                begin
                    next_ack = 1'b1;
                    next_state = smbus_port_pkg::st_count;
                end
                smbus_port_pkg::st_count:
                begin
                    next_ack = 1'b1;
                    next_state = smbus_port_pkg::st_wdata;
                end
                smbus_port_pkg::st_wdata:
                    next_ack = 1'b1;
                default:
                    next_ack = 1'b0;
            endcase
        end
    end

    always_ff @(posedge scl or posedge frame_clear)
    begin
        if (frame_clear)
        begin
            state <= smbus_port_pkg::st_addr;
            bit_cnt <= `BIT_FIRST;
            shift <= 8'h00;
            ack <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ack <= next_ack;
            bit_cnt <= ack_slot ? `BIT_FIRST : bit_cnt + 4'h1;
            shift <= rx_byte;
        end
    end

    // ****************************************************************
    // Link side: location, count and transmit byte
    // ****************************************************************
    always_ff @(posedge scl or posedge link_init)
    begin
        if (link_init)
        begin
            loc <= 8'h00;
            count <= 8'h00;
            tx <= 8'h00;
        end
        else if (byte_end && state == smbus_port_pkg::st_loc)
            loc <= rx_byte;
        else if (byte_end && state == smbus_port_pkg::st_count)
            count <= rx_byte;
        else if (byte_end && state == smbus_port_pkg::st_wdata)
            loc <= loc + 8'h01;
        else if (byte_end && state == smbus_port_pkg::st_addr
            && addr_match && rx_byte[0])
            tx <= `CFG_BYTES;
        else if (ack_slot && transmitting && !ack && !sda_in)
        begin
            tx <= rd_byte;
            loc <= loc + 8'h01;
        end
        else if (transmitting && !ack_slot)
            tx <= {tx[6:0], 1'b0};
    end

    always_ff @(posedge scl)
    begin
        if (byte_end && state == smbus_port_pkg::st_wdata && in_range)
            mem[loc[2:0]] <= rx_byte;
    end

    // ****************************************************************
    // Link side: data line drive on the falling bus clock
    // ****************************************************************
    assign next_sda_oe = ack_slot ? ack : (transmitting && !tx[7]);

    always_ff @(negedge scl or posedge frame_clear)
    begin
        if (frame_clear)
            sda_oe <= 1'b0;
        else
            sda_oe <= next_sda_oe;
    end

    // ****************************************************************
    // Store image for the rest of the chip
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `CFG_BYTES; gi = gi + 1)
        begin : g_image
            always_ff @(posedge clk)
            begin
                if (rst)
                    cfg_image[gi*8 +: 8] <= 8'h00;
                else if (copy_now)
                    cfg_image[gi*8 +: 8] <= mem[gi];
            end
        end
    endgenerate

    // ****************************************************************
    // Checks
    // ****************************************************************
    wire in_write = (state == smbus_port_pkg::st_loc)
        || (state == smbus_port_pkg::st_count)
        || (state == smbus_port_pkg::st_wdata);
    wire ignoring = (state == smbus_port_pkg::st_ignore);

    sequence s_acked;
        ack && sda_oe;
    endsequence

    sequence s_released;
        ignoring ##1 !sda_oe;
    endsequence

    property p_read_match;
        @(posedge scl) disable iff (frame_clear)
        (byte_end && state == smbus_port_pkg::st_addr && addr_match
            && rx_byte[0]) |=> transmitting ##0 s_acked;
    endproperty
    a_read_match: assert property (p_read_match)
        else $error("read address not taken");

    property p_stop_close;
        @(posedge clk) disable iff (rst)
        stop_seen |=> frame_clear && copy_now;
    endproperty
    a_stop_close: assert property (p_stop_close)
        else $error("stop did not close the frame");

    property p_fixed_bits;
        @(posedge scl) disable iff (frame_clear)
        (byte_end && state == smbus_port_pkg::st_addr
            && shift[6:3] != 4'hd) |=> s_released;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("wrong fixed address bits answered");

    property p_strap_held;
        @(posedge clk) disable iff (rst)
        strap_taken |=> $stable(bus_address_strap);
    endproperty
    a_strap_held: assert property (p_strap_held)
        else $error("address strap changed after latch");

    property p_write_ack;
        @(posedge scl) disable iff (frame_clear)
        (byte_end && in_write) |=> s_acked ##1 (bit_cnt == `BIT_FIRST);
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("write byte not acknowledged");

    property p_host_nack;
        @(posedge scl) disable iff (frame_clear)
        (ack_slot && transmitting && !ack && sda_in) |=> s_released;
    endproperty
    a_host_nack: assert property (p_host_nack)
        else $error("read did not end on not-acknowledge");

    property p_host_ack;
        @(posedge scl) disable iff (frame_clear)
        (ack_slot && transmitting && !ack && !sda_in)
            |=> (state == smbus_port_pkg::st_rdata) && !ack;
    endproperty
    a_host_ack: assert property (p_host_ack)
        else $error("read did not continue on acknowledge");

    property p_mismatch;
        @(posedge scl) disable iff (frame_clear)
        (byte_end && state == smbus_port_pkg::st_addr && !addr_match)
            |=> !ack ##0 s_released;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("foreign address acknowledged");

endmodule

`default_nettype wire

// ---- tb/smbus_host.sv ----
// SMBus host model that drives the link clock and the data wire.
// Assumes the target pulls the wire low only while sda_oe is high.
`timescale 1ns/1ps
`default_nettype none

module smbus_host (
    input wire logic sda_oe,
    input wire logic sda_out,
    output logic scl,
    output logic sda_in
);
    logic pull_low = 1'b0;
    initial scl = 1'b1;
    // Pulled-up wire, either party may pull it low
    assign sda_in = !((sda_oe && !sda_out) || pull_low);

    // ********************
    // Bit and frame timing
    // ********************
    // Data changes only mid low phase; clock stands still between frames
    task automatic bit_io(input logic b, output logic got);
        #20 pull_low = !b;
        #20 scl = 1'b1;
        #20 got = sda_in;
        #20 scl = 1'b0;
    endtask

    task automatic start();
        #23 pull_low = 1'b0;
        #20 scl = 1'b1;
        #40 pull_low = 1'b1;
        #80 scl = 1'b0;
    endtask

    // Stop may follow any whole byte
    task automatic stop();
        #20 pull_low = 1'b1;
        #20 scl = 1'b1;
        #40 pull_low = 1'b0;
        #80;
    endtask

    // ********************
    // Bytes, MSB first
    // ********************
    task automatic send(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], g);
        bit_io(1'b1, g);
        ack = !g;
    endtask

    // Host acks each byte, not-acks the last
    task automatic recv(input logic ack, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(!ack, g);
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_smbus_block_target_port.sv ----
// Self-checking bench for the SMBus block target port.
// Assumes smbus_host forms the wire and the link clock.
`timescale 1ns/1ps
`default_nettype none

module tb_smbus_block_target_port;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] strap = 2'h0;
    logic scl, sda_in, sda_out, sda_oe;
    logic [2:0] addr_low;
    logic [63:0] image;
    logic [7:0] mem [8];
    logic [2:0] low = 3'h0;
    int n_mismatch = 0;
    int comparisons = 0;

    always #5 clk = ~clk;

    smbus_block_target_port u_smbus_block_target_port (
        .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .three_level_address_strap_pin(strap),
        .bus_address_strap(addr_low), .cfg_image(image)
    );
    smbus_host u_smbus_host (
        .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda_in(sda_in)
    );

    // ********************
    // Compare and verdict
    // ********************
    task automatic check_bit(input logic g, input logic e, input string w);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %0t: %s got %b want %b", $time, w, g, e);
        end
    endtask

    task automatic check_word(input logic [63:0] g, input logic [63:0] e,
        input string w);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %0t: %s got %h want %h", $time, w, g, e);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [63:0] exp_image();
        logic [63:0] r;
        for (int i = 0; i < 8; i++)
            r[8*i +: 8] = mem[i];
        return r;
    endfunction

    // ********************
    // Transfers
    // ********************
    task automatic do_reset(input logic [1:0] code);
        @(posedge clk);
        rst <= 1'b1;
        strap <= code;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic head(input logic [7:0] n);
        logic a;
        u_smbus_host.start();
        u_smbus_host.send({4'hd, low, 1'b0}, a);
        check_bit(a, 1'b1, "addr ack");
        u_smbus_host.send(n, a);
        check_bit(a, 1'b1, "loc ack");
    endtask

    task automatic blk_write(input logic [7:0] n, input logic [7:0] x,
        input int cnt, input logic [7:0] v);
        logic a;
        head(n);
        u_smbus_host.send(x, a);
        check_bit(a, 1'b1, "count ack");
        for (int i = 0; i < cnt; i++)
        begin
            u_smbus_host.send(v + 8'(i), a);
            check_bit(a, 1'b1, "data ack");
            if (n + i < 8)
                mem[n + i] = v + 8'(i);
        end
        u_smbus_host.stop();
        repeat (8) @(posedge clk);
        check_word(image, exp_image(), "image");
    endtask

    task automatic blk_read(input logic [7:0] n, input int cnt);
        logic a;
        logic [7:0] d;
        head(n);
        u_smbus_host.start();
        u_smbus_host.send({4'hd, low, 1'b1}, a);
        check_bit(a, 1'b1, "read addr ack");
        u_smbus_host.recv(1'b1, d);
        check_word(64'(d), 64'h8, "count");
        for (int i = 0; i < cnt; i++)
        begin
            u_smbus_host.recv(i < cnt - 1, d);
            check_word(64'(d), n + i < 8 ? 64'(mem[n + i]) : 64'h0,
                "read data");
        end
        u_smbus_host.stop();
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic test_strap();
        logic [2:0] map [4] = '{3'h0, 3'h1, 3'h2, 3'h1};
        for (int c = 0; c < 4; c++)
        begin
            do_reset(2'(c));
            low = map[c];
            check_word(64'(addr_low), 64'(low), "strap");
            @(posedge clk);
            strap <= ~2'(c);
            repeat (8) @(posedge clk);
            check_word(64'(addr_low), 64'(low), "strap held");
            blk_write(8'h00, 8'h08, 8, 8'h11 + 8'(c));
        end
        $display("test strap done");
    endtask

    task automatic test_write_read();
        blk_write(8'h03, 8'h02, 2, 8'ha0);
        blk_read(8'h03, 3);
        blk_read(8'h06, 3);
        $display("test write read done");
    endtask

    task automatic test_early_stop();
        blk_write(8'h05, 8'h03, 1, 8'h5c);
        blk_read(8'h00, 1);
        blk_read(8'h04, 2);
        $display("test early stop done");
    endtask

    task automatic test_refused();
        logic a;
        logic [7:0] bad [3];
        bad[0] = {4'h5, low, 1'b0};
        bad[1] = {4'hd, low ^ 3'h1, 1'b0};
        bad[2] = {4'hd, low ^ 3'h2, 1'b1};
        foreach (bad[k])
        begin
            u_smbus_host.start();
            u_smbus_host.send(bad[k], a);
            check_bit(a, 1'b0, "foreign addr");
            u_smbus_host.send(8'h00, a);
            check_bit(a, 1'b0, "ignored byte");
            u_smbus_host.stop();
        end
        repeat (8) @(posedge clk);
        check_word(image, exp_image(), "image kept");
        blk_read(8'h00, 2);
        $display("test refused done");
    endtask

    initial
    begin
        test_strap();
        test_write_read();
        test_early_stop();
        test_refused();
        give_verdict();
    end

    initial
    begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
